//--- core/odr_pkg.sv
// Purpose: Shared types and constants for the operand addressing stage
// Assumes: 8-bit data path, one clock, async active-low reset
// Notes:   Mode, register select and memory request carriers
package odr_pkg;
	// ----------------------------------------
	// Constants
	// ----------------------------------------
	localparam int unsigned DATA_W    = 8;
	localparam logic [7:0]  PCL_RESET = 8'h00;
	localparam logic [7:0]  ZERO_BYTE = 8'h00;
	localparam logic [7:0]  PCL_LAST  = 8'hff;
	localparam logic [1:0]  LEN_TWO   = 2'h2;
	localparam logic [1:0]  LEN_THREE = 2'h3;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		M_SRC_IMM,
		M_SRC_DIR,
		M_SRC_IDX,
		M_DST_DIR,
		M_DST_IDX,
		M_DST_DIR_IMM,
		M_DST_IDX_IMM,
		M_MEM_MEM
	} odr_mode_t;

	typedef enum logic [1:0] {SEL_A, SEL_X, SEL_SP, SEL_F} odr_sel_t;
	typedef enum logic {SPC_RAM, SPC_REG} odr_space_t;

	typedef struct packed {
		odr_mode_t  mode;
		odr_sel_t   sel;
		odr_space_t space;
		logic       arith;
	} odr_cmd_t;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] x;
		logic [7:0] stack_top_pointer;
		logic [7:0] f;
	} odr_regs_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		odr_space_t space;
		logic [7:0] addr;
		logic [7:0] wdata;
	} odr_mem_req_t;

	typedef struct packed {
		logic       en;
		odr_sel_t   sel;
		logic [7:0] data;
	} odr_reg_wr_t;
endpackage : odr_pkg

//--- core/odr_addr_form.sv
// Purpose: Effective address former, direct or indexed
// Assumes: Address and index share one width
// Notes:   Carry out of the top bit is dropped
`timescale 1ns/10ps
`default_nettype none
module odr_addr_form #(
	parameter int unsigned W = 8
) (
	// Operands
	input  wire logic [W-1:0] base_i,
	input  wire logic [W-1:0] index_i,
	input  wire logic         use_index_i,
	// Result
	output logic      [W-1:0] addr_o
);
	if (W < 1) begin : g_w_check
		$error("odr_addr_form: W must be at least 1");
	end

	// Wraps inside the page, no carry kept
	assign addr_o = use_index_i ? W'(base_i + index_i) : base_i; // RULE_15
endmodule : odr_addr_form
`default_nettype wire

//--- core/odr_operand_addressing_decode.sv
// Purpose: Operand fetch and addressing for an 8-bit core
// Assumes: Program byte valid same cycle as its address; data read returns one cycle later
// Notes:   ALU sits outside; result comes back in the execute cycle
// Function
// (RULE_01) Program counter low byte, 8 bits, zero at reset, not register-writable.
// (RULE_02) Source immediate: literal operand, result to A, F, SP or X; two bytes.
// (RULE_03) Source immediate arithmetic uses the selected A, X, SP or F as second input.
// (RULE_04) Source direct: operand addresses RAM or register space, result to A or X; two bytes.
// (RULE_05) Source direct/indexed arithmetic combines fetched value with selected A or X.
// (RULE_06) Source indexed: operand plus X forms source address, result A or X; two bytes.
// (RULE_07) Destination direct: result to addressed location, source A or X; two bytes.
// (RULE_08) Destination direct arithmetic reads the target as second input, writes back there.
// (RULE_09) Destination modes leave the accumulator untouched, only the target changes.
// (RULE_10) Destination indexed: operand plus X addresses result, source A; two bytes.
// (RULE_11) Indexed destination arithmetic reads operand plus X, writes result back there.
// (RULE_12) Destination direct immediate: address byte then literal byte; three bytes.
// (RULE_13) Destination indexed immediate: first byte plus X addresses, second literal; three bytes.
// (RULE_14) Memory-to-memory copy only: first operand RAM destination, second RAM source; three bytes.
// (RULE_15) Indexed address is an 8-bit sum, carry discarded.
// (RULE_16) Operand bytes fetched in order after opcode; counter passes every byte.
`timescale 1ns/10ps
`default_nettype none
module odr_operand_addressing_decode
	import odr_pkg::*;
#(
	parameter int unsigned DW = DATA_W
) (
	// Clock and reset
	input  wire logic         sys_clk_i,
	input  wire logic         reset_n_i,
	// Instruction start, decoded from opcode at program_counter_low_o
	input  wire logic         start_i,
	input  wire odr_cmd_t     cmd_i,
	output logic              busy_o,
	output logic              done_o,
	output logic [1:0]        ilen_o,
	// Program memory
	output logic [DW-1:0]     program_counter_low_o,
	output logic              pc_carry_o,
	input  wire logic [DW-1:0] pmem_data_i,
	// Core registers
	input  wire odr_regs_t    regs_i,
	output odr_reg_wr_t       reg_wr_o,
	// Data memory and register space
	output odr_mem_req_t      mem_req_o,
	input  wire logic [DW-1:0] mem_rdata_i,
	// Arithmetic unit
	output logic              alu_go_o,
	output logic              alu_arith_o,
	output logic [DW-1:0]     alu_in1_o,
	output logic [DW-1:0]     alu_in2_o,
	input  wire logic [DW-1:0] alu_result_i
);
	if (DW != DATA_W) begin : g_dw_check
		$error("odr: only 8-bit data supported");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [2:0] {S_IDLE, S_OPND1, S_OPND2, S_READ, S_LOAD, S_EXEC, S_WRITE} odr_state_t;

	odr_state_t state;
	odr_cmd_t   cmd_q;
	logic [7:0] program_counter_low;
	logic [7:0] op1;
	logic [7:0] op2;
	logic [7:0] mem_val;
	logic [7:0] eff_addr;
	logic [7:0] result;
	logic [7:0] formed_addr;
	logic [7:0] sel_val;
	logic       pc_step;
	logic       has_op2;
	logic       needs_read;
	logic       src_mode;
	logic       indexed;
	odr_cmd_t   next_cmd;

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	always_comb begin
		next_cmd = cmd_i;
		if (cmd_i.mode == M_DST_IDX) begin
			next_cmd.sel = SEL_A; // RULE_10
		end
		if (cmd_i.mode == M_MEM_MEM) begin
			next_cmd.space = SPC_RAM; // RULE_14
			next_cmd.arith = 1'b0; // RULE_14
		end
	end

	assign has_op2  = (cmd_q.mode == M_DST_DIR_IMM) || (cmd_q.mode == M_DST_IDX_IMM)
		|| (cmd_q.mode == M_MEM_MEM); // RULE_12 RULE_13 RULE_14
	assign src_mode = (cmd_q.mode == M_SRC_IMM) || (cmd_q.mode == M_SRC_DIR) || (cmd_q.mode == M_SRC_IDX);
	assign indexed  = (cmd_q.mode == M_SRC_IDX) || (cmd_q.mode == M_DST_IDX) || (cmd_q.mode == M_DST_IDX_IMM);
	// Destination arithmetic needs the old target value
	assign needs_read = (cmd_q.mode == M_SRC_DIR) || (cmd_q.mode == M_SRC_IDX) || (cmd_q.mode == M_MEM_MEM)
		|| (!src_mode && cmd_q.arith); // RULE_08 RULE_11

	odr_addr_form #(
		.W (8)
	) u_addr_form (
		.base_i      (pmem_data_i),
		.index_i     (regs_i.x),
		.use_index_i (indexed),
		.addr_o      (formed_addr)
	);

	always_comb begin
		case (cmd_q.sel)
			SEL_A:   sel_val = regs_i.a;
			SEL_X:   sel_val = regs_i.x;
			SEL_SP:  sel_val = regs_i.stack_top_pointer;
			SEL_F:   sel_val = regs_i.f;
			default: sel_val = regs_i.a;
		endcase
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= S_IDLE;
		end else begin
			case (state)
				S_IDLE:  if (start_i) state <= S_OPND1;
				S_OPND1: state <= has_op2 ? S_OPND2 : (needs_read ? S_READ : S_EXEC); // RULE_16
				S_OPND2: state <= needs_read ? S_READ : S_EXEC;
				S_READ:  state <= S_LOAD;
				S_LOAD:  state <= S_EXEC;
				S_EXEC:  state <= S_WRITE;
				S_WRITE: state <= S_IDLE;
				default: state <= S_IDLE;
			endcase
		end
	end

	// Opcode, then each operand byte, moves the counter
	assign pc_step = (state == S_IDLE && start_i) || state == S_OPND1 || state == S_OPND2; // RULE_16

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			program_counter_low <= PCL_RESET; // RULE_01
			pc_carry_o          <= 1'b0;
		end else begin
			pc_carry_o <= pc_step && (program_counter_low == PCL_LAST);
			if (pc_step) program_counter_low <= program_counter_low + 8'h01; // RULE_16
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmd_q    <= '0;
			op1      <= ZERO_BYTE;
			op2      <= ZERO_BYTE;
			eff_addr <= ZERO_BYTE;
		end else begin
			if (state == S_IDLE && start_i) cmd_q <= next_cmd;
			if (state == S_OPND1) begin
				op1      <= pmem_data_i;
				eff_addr <= formed_addr; // RULE_06 RULE_10 RULE_13
			end
			if (state == S_OPND2) op2 <= pmem_data_i; // RULE_12
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mem_val <= ZERO_BYTE;
			result  <= ZERO_BYTE;
			ilen_o  <= 2'h0;
		end else begin
			if (state == S_LOAD) mem_val <= mem_rdata_i;
			if (state == S_EXEC) begin
				result <= alu_result_i;
				ilen_o <= has_op2 ? LEN_THREE : LEN_TWO; // RULE_02 RULE_04 RULE_07 RULE_12
			end
		end
	end

	// ----------------------------------------
	// Operand routing to the arithmetic unit
	// ----------------------------------------
	always_comb begin
		case (cmd_q.mode)
			M_SRC_IMM: begin
				alu_in1_o = op1; // RULE_02
				alu_in2_o = sel_val; // RULE_03
			end
			M_SRC_DIR, M_SRC_IDX: begin
				alu_in1_o = mem_val; // RULE_04 RULE_06
				alu_in2_o = sel_val; // RULE_05
			end
			M_DST_DIR, M_DST_IDX: begin
				alu_in1_o = sel_val; // RULE_07
				alu_in2_o = mem_val; // RULE_08 RULE_11
			end
			M_DST_DIR_IMM, M_DST_IDX_IMM: begin
				alu_in1_o = op2; // RULE_12 RULE_13
				alu_in2_o = mem_val; // RULE_11
			end
			M_MEM_MEM: begin
				alu_in1_o = mem_val; // RULE_14
				alu_in2_o = ZERO_BYTE;
			end
			default: begin
				alu_in1_o = op1;
				alu_in2_o = ZERO_BYTE;
			end
		endcase
	end

	assign alu_go_o    = (state == S_EXEC);
	assign alu_arith_o = cmd_q.arith;

	// ----------------------------------------
	// Memory, register space and register writes
	// ----------------------------------------
	always_comb begin
		mem_req_o       = '0;
		mem_req_o.space = cmd_q.space;
		mem_req_o.wdata = result;
		mem_req_o.addr  = eff_addr;
		if (state == S_READ) begin
			mem_req_o.rd = 1'b1;
			// Copy reads its source from the second operand
			if (cmd_q.mode == M_MEM_MEM) mem_req_o.addr = op2; // RULE_14
		end
		if (state == S_WRITE && !src_mode) mem_req_o.wr = 1'b1; // RULE_07 RULE_09
	end

	always_comb begin
		reg_wr_o      = '0;
		reg_wr_o.sel  = cmd_q.sel;
		reg_wr_o.data = result;
		// Destination forms never touch A, even with A as source
		reg_wr_o.en   = (state == S_WRITE) && src_mode; // RULE_09 RULE_02 RULE_04 RULE_06
	end

	assign busy_o                = (state != S_IDLE);
	assign done_o                = (state == S_WRITE);
	assign program_counter_low_o = program_counter_low; // RULE_01

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	pc_step_a: assert property (pc_step |=> program_counter_low == $past(program_counter_low) + 8'h01) // RULE_16
		else $error("counter did not advance on fetch");
	pc_hold_a: assert property (!pc_step |=> $stable(program_counter_low)) // RULE_01
		else $error("counter moved without fetch");
	len_two_a: assert property (done_o && cmd_q.mode <= M_DST_IDX |-> ilen_o == LEN_TWO) // RULE_02
		else $error("two-byte length wrong");
	len_three_a: assert property (done_o && cmd_q.mode >= M_DST_DIR_IMM |-> ilen_o == LEN_THREE) // RULE_12
		else $error("three-byte length wrong");
	acc_kept_a: assert property (done_o && !src_mode // RULE_09
		|-> !reg_wr_o.en && mem_req_o.wdata == $past(alu_result_i))
		else $error("register written in destination mode");
	idx_addr_a: assert property (state == S_OPND1 && indexed |=> // RULE_15
		eff_addr == 8'($past(pmem_data_i) + $past(regs_i.x)))
		else $error("indexed address wrong");
	dst_wr_a: assert property (state == S_EXEC && !src_mode |=> mem_req_o.wr && mem_req_o.addr == eff_addr) // RULE_07
		else $error("destination write missing");
	copy_src_a: assert property (state == S_READ && cmd_q.mode == M_MEM_MEM |-> // RULE_14
		mem_req_o.addr == op2 && mem_req_o.space == SPC_RAM)
		else $error("copy source address wrong");
	rd_then_exec_a: assert property (mem_req_o.rd |=> ##1 // RULE_05
		alu_go_o && (alu_in2_o == mem_val || alu_in1_o == mem_val))
		else $error("fetched value not routed");
	imm_lat_a: assert property (state == S_IDLE && start_i && next_cmd.mode == M_SRC_IMM |-> ##3 done_o) // RULE_02
		else $error("immediate instruction late");

	imm_cov: cover property (done_o && cmd_q.mode == M_SRC_IMM);
	dst_arith_cov: cover property (done_o && cmd_q.mode == M_DST_IDX && cmd_q.arith);
	copy_cov: cover property (done_o && cmd_q.mode == M_MEM_MEM);
	wrap_cov: cover property (pc_carry_o);
endmodule : odr_operand_addressing_decode
`default_nettype wire

//--- testbench/odr_mem_model.sv
// Purpose: Data memory and register space behind the addressing stage
// Assumes: Read data valid one cycle after the read pulse
// Notes:   Outside that cycle the bus shows the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module odr_mem_model
	import odr_pkg::*;
(
	// Clock and request
	input  wire logic         sys_clk_i,
	input  wire odr_mem_req_t mem_req_i,
	// Read data
	output logic [7:0]        rdata_o
);
	logic [7:0] ram [256];
	logic [7:0] rsp [256];
	logic [7:0] last;
	logic       valid;

	// Address-dependent contents, so a wrong address shows
	initial begin
		for (int i = 0; i < 256; i++) begin
			ram[i] = 8'(i) ^ 8'h5a;
			rsp[i] = 8'(i) + 8'h33;
		end
		last = 8'h00;
		valid = 1'b0;
	end

	always @(posedge sys_clk_i) begin
		valid <= mem_req_i.rd;
		if (mem_req_i.rd)
			last <= (mem_req_i.space == SPC_REG) ? rsp[mem_req_i.addr] : ram[mem_req_i.addr];
		if (mem_req_i.wr && mem_req_i.space == SPC_REG)
			rsp[mem_req_i.addr] <= mem_req_i.wdata;
		if (mem_req_i.wr && mem_req_i.space == SPC_RAM)
			ram[mem_req_i.addr] <= mem_req_i.wdata;
	end

	// Stale data never looks valid
	assign rdata_o = valid ? last : ~last;
endmodule : odr_mem_model
`default_nettype wire

//--- testbench/odr_operand_addressing_decode_tb_top.sv
// Purpose: Self-checking bench for the operand addressing stage
// Assumes: Outside unit adds when arith is set, else passes in1
// Notes:   Random instructions with a few corner cases first
`timescale 1ns/10ps
`default_nettype none
module odr_operand_addressing_decode_tb_top;
	import odr_pkg::*;
	logic         sys_clk_i, reset_n_i, start_i, busy_o, done_o, pc_carry_o, alu_go_o, alu_arith_o;
	odr_cmd_t     cmd_i;
	logic [1:0]   ilen_o;
	logic [7:0]   pc, rdata, in1, in2, prog [256];
	odr_regs_t    regs_i;
	odr_reg_wr_t  reg_wr_o, wr_seen;
	odr_mem_req_t mem_req_o;
	int           errors, samples_checked, carries, bytes;

	odr_operand_addressing_decode odr_operand_addressing_decode_i (
		.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .start_i(start_i), .cmd_i(cmd_i),
		.busy_o(busy_o), .done_o(done_o), .ilen_o(ilen_o), .program_counter_low_o(pc),
		.pc_carry_o(pc_carry_o), .pmem_data_i(prog[pc]), .regs_i(regs_i), .reg_wr_o(reg_wr_o),
		.mem_req_o(mem_req_o), .mem_rdata_i(rdata), .alu_go_o(alu_go_o), .alu_arith_o(alu_arith_o),
		.alu_in1_o(in1), .alu_in2_o(in2), .alu_result_i(alu_arith_o ? in1 + in2 : in1));
	odr_mem_model odr_mem_model_i (.sys_clk_i(sys_clk_i), .mem_req_i(mem_req_o), .rdata_o(rdata));

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) if (pc_carry_o === 1'b1) carries++;

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim

	// ----------------------------------------
	// One instruction, expectation from mode
	// ----------------------------------------
	task automatic run(input odr_mode_t m, input odr_sel_t s, input odr_space_t sp, input logic ar,
		input logic [7:0] o1, input logic [7:0] o2, input logic bump);
		logic [7:0] p0, ad, wa, mv, rv, src, sec, ex;
		logic [1:0] len;
		int n, gos;
		p0 = pc;
		cmd_i = '{m, s, sp, ar};
		prog[p0 + 8'h1] = o1;
		prog[p0 + 8'h2] = o2;
		len = (m >= M_DST_DIR_IMM) ? LEN_THREE : LEN_TWO;
		if (m == M_DST_IDX) s = SEL_A;
		if (m == M_MEM_MEM) sp = SPC_RAM;
		ad = (m inside {M_SRC_IDX, M_DST_IDX, M_DST_IDX_IMM}) ? o1 + regs_i.x : o1;
		if (m == M_MEM_MEM) ad = o2;
		wa = (m == M_MEM_MEM) ? o1 : ad;
		mv = (sp == SPC_REG) ? odr_mem_model_i.rsp[ad] : odr_mem_model_i.ram[ad];
		rv = 8'(regs_i >> (8 * (3 - int'(s))));
		src = mv;
		sec = mv;
		case (m)
			M_SRC_IMM: begin src = o1; sec = rv; end
			M_SRC_DIR, M_SRC_IDX: sec = rv;
			M_DST_DIR, M_DST_IDX: src = rv;
			M_DST_DIR_IMM, M_DST_IDX_IMM: src = o2;
			default: ar = 1'b0;
		endcase
		ex = ar ? src + sec : src;
		start_i = 1'b1;
		@(negedge sys_clk_i);
		chk("busy", 8'h1, {7'h0, busy_o});
		start_i = bump;
		wr_seen = '0;
		n = 0;
		gos = 0;
		while (done_o !== 1'b1 && n < 20) begin
			@(negedge sys_clk_i);
			start_i = 1'b0;
			n++;
			if (reg_wr_o.en === 1'b1) wr_seen = reg_wr_o;
			if (alu_go_o === 1'b1) gos++;
		end
		chk("done", 8'h1, {7'h0, done_o});
		chk("ilen", {6'h0, len}, {6'h0, ilen_o});
		@(negedge sys_clk_i);
		chk("pc", p0 + {6'h0, len}, pc);
		chk("busy_end", 8'h0, {7'h0, busy_o});
		chk("alu_go", 8'h1, 8'(gos));
		if (m <= M_SRC_IDX) begin
			chk("reg_sel", {6'h0, s}, {6'h0, wr_seen.sel});
			chk("reg_data", ex, wr_seen.data);
		end else begin
			chk("reg_untouched", 8'h0, {7'h0, wr_seen.en});
			chk("mem_data", ex, (sp == SPC_REG) ? odr_mem_model_i.rsp[wa] : odr_mem_model_i.ram[wa]);
		end
		bytes += int'(len);
	endtask : run

	initial begin
		#200us;
		errors++;
		end_sim();
	end

	initial begin
		odr_mode_t m;
		logic [1:0] s;
		void'($urandom(77));
		{reset_n_i, start_i, errors, samples_checked, carries, bytes} = '0;
		cmd_i = '0;
		regs_i = '0;
		foreach (prog[i]) prog[i] = 8'h00;
		repeat (5) @(negedge sys_clk_i);
		reset_n_i = 1'b1;
		chk("pc_reset", PCL_RESET, pc);
		// Index wrap corners and the copy with its operand order
		regs_i = '{8'h10, 8'hff, 8'h20, 8'h30};
		run(M_SRC_IDX, SEL_A, SPC_RAM, 1'b1, 8'hff, 8'h00, 1'b1);
		run(M_DST_IDX_IMM, SEL_X, SPC_REG, 1'b1, 8'h02, 8'h44, 1'b0);
		run(M_MEM_MEM, SEL_A, SPC_REG, 1'b1, 8'h07, 8'h08, 1'b1);
		for (int i = 0; i < 300; i++) begin
			regs_i = odr_regs_t'($urandom);
			m = odr_mode_t'($urandom_range(0, 7));
			s = 2'($urandom_range(0, 3));
			if (m inside {M_SRC_DIR, M_SRC_IDX, M_DST_DIR}) s[1] = 1'b0;
			run(m, odr_sel_t'(s), odr_space_t'($urandom_range(0, 1)), 1'($urandom), 8'($urandom),
				8'($urandom), 1'($urandom));
		end
		chk("carries", 8'(bytes / 256), 8'(carries));
		reset_n_i = 1'b0;
		@(negedge sys_clk_i);
		chk("pc_rereset", PCL_RESET, pc);
		reset_n_i = 1'b1;
		run(M_SRC_IMM, SEL_F, SPC_RAM, 1'b1, 8'h0f, 8'h00, 1'b0);
		end_sim();
	end
endmodule : odr_operand_addressing_decode_tb_top
`default_nettype wire
